// file: shared/pcr_pkg.sv
// constants for the power-management register slice
package pcr_pkg;
    // ========================================
    // register offsets
    localparam logic [7:0] ADDR_DISCH3 = 8'h42; // offset not printed
    localparam logic [7:0] ADDR_POWER_GOOD_DELAY_ONE = 8'h43;
    localparam logic [7:0] ADDR_SHUTDN = 8'h91;
    localparam logic [7:0] ADDR_BUCK_REGULATOR_ONE_SLP = 8'h92;
    // ========================================
    // write masks and reset values
    localparam logic [7:0] MASK_DISCH3 = 8'h3f;
    localparam logic [7:0] MASK_POWER_GOOD_DELAY_ONE = 8'h07;
    localparam logic [7:0] MASK_BUCK_REGULATOR_ONE_SLP = 8'hff;
    localparam logic [7:0] RST_DISCH3 = 8'h15;
    localparam logic [7:0] RST_POWER_GOOD_DELAY_ONE = 8'h00;
    localparam logic [7:0] RST_BUCK_REGULATOR_ONE_SLP = 8'h00;
    // ========================================
    // field positions
    localparam int SW2_LSB = 4;
    localparam int SW1_LSB = 2;
    localparam int LR3_LSB = 0;
    localparam int FORCE_SHUTDOWN_BIT_BIT = 0;
    localparam int SLP_EN_BIT = 0;
    localparam int SLP_VID_LSB = 1;
    // ========================================
    // timing: 10 MHz clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_MS_X10 = CLK_HZ / 10_000; // cycles per 0.1 ms
    // delays in tenths of a millisecond
    localparam int DLY_X10_0 = 25;
    localparam int DLY_X10_1 = 50;
    localparam int DLY_X10_2 = 100;
    localparam int DLY_X10_3 = 150;
    localparam int DLY_X10_4 = 200;
    localparam int DLY_X10_5 = 500;
    localparam int DLY_X10_6 = 750;
    localparam int DLY_X10_7 = 1000;
    localparam int CNT_W = 20;
endpackage : pcr_pkg

// file: design/pcr_regs.sv
// register slice: discharge, pg delay, forced shutdown, buck one sleep
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: three 2-bit discharge selects choose none, 100, 200 or 500 ohms
// RULE2: output three power good rises only after delay since rails good
// RULE3: delay codes map to 2.5,5,10,15,20,50,75,100 ms
// RULE4: delay ignored when output three is register driven, not vtt
// RULE5: writing one to shutdown bit resets device and all registers
// RULE6: shutdown bit clears itself and reads zero afterwards
// RULE7: no acknowledge returned for the write setting shutdown bit
// RULE8: bits 7:1 of buck one sleep register hold sleep voltage code
// RULE9: sleep enable low uses normal code; high uses sleep code on pin low
// RULE10: sleep request from factory-selected control input three or six
// RULE11: host expects missing acknowledge and waits for restart
// RULE12: reserved bits read zero and ignore writes
module pcr_regs #(
    parameter logic [7:0] BUCK_REGULATOR_ONE_NORM_RST = 8'h00, // arbitrary default
    parameter int DLY_SCALE = 1 // divides delay counts for simulation
) (
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic rst_i, // sync reset, active high
    input wire logic wr_en_i, // register write strobe
    input wire logic [7:0] addr_i, // register offset
    input wire logic [7:0] wdata_i, // write data
    output logic [7:0] rdata_o, // read data
    output logic ack_o, // write acknowledge
    input wire logic [6:0] buck_one_normal_voltage_code_i, // normal code
    input wire logic sleep_pin_sel_i, // factory: 0 input three, 1 six
    input wire logic control_input_three_sleep_i, // sleep pin three
    input wire logic control_input_six_sleep_i, // sleep pin six
    input wire logic rails_good_i, // all grouped rails in regulation
    input wire logic general_output_three_i2c_mode_i, // output three driven by register
    input wire logic general_output_three_vtt_use_i, // output three enables vtt regulator
    input wire logic general_output_three_i2c_level_i, // register level for output three
    output logic general_output_three_o, // output pin three
    output logic [1:0] switch_two_discharge_sel_o, // discharge select
    output logic [1:0] switch_one_discharge_sel_o, // discharge select
    output logic [1:0] linreg_three_discharge_sel_o, // discharge select
    output logic [6:0] buck_one_vid_o, // active voltage code
    output logic shutdown_o // emergency shutdown pulse
);
    import pcr_pkg::*;

    // ========================================
    // registers
    logic [7:0] disch3_r;
    logic [7:0] pgdly_r;
    logic [7:0] slp_r;
    logic force_shutdown_bit_r;
    logic [CNT_W-1:0] cnt_r;
    logic pg_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic pg_nxt;

    // address decode
    wire sel_d3 = addr_i == ADDR_DISCH3;
    wire sel_pg = addr_i == ADDR_POWER_GOOD_DELAY_ONE;
    wire sel_sd = addr_i == ADDR_SHUTDN;
    wire sel_sl = addr_i == ADDR_BUCK_REGULATOR_ONE_SLP;
    wire sd_wr = wr_en_i && sel_sd && wdata_i[FORCE_SHUTDOWN_BIT_BIT]; // [RULE5]
    wire wr_ok = wr_en_i && !sd_wr;
    wire dev_rst = rst_i || force_shutdown_bit_r; // [RULE5]

    // ========================================
    // register writes, reserved bits masked
    always_ff @(posedge ref_clk_i)
    begin
        if (dev_rst)
        begin
            disch3_r <= RST_DISCH3;
            pgdly_r <= RST_POWER_GOOD_DELAY_ONE;
            slp_r <= RST_BUCK_REGULATOR_ONE_SLP;
        end
        else if (wr_ok)
        begin
            if (sel_d3)
                disch3_r <= wdata_i & MASK_DISCH3; // [RULE12]
            if (sel_pg)
                pgdly_r <= wdata_i & MASK_POWER_GOOD_DELAY_ONE; // [RULE12]
            if (sel_sl)
                slp_r <= wdata_i & MASK_BUCK_REGULATOR_ONE_SLP; // [RULE8]
        end
    end

    // shutdown bit: set by write, cleared by its own reset next cycle
    // the pulse itself is the device reset, so it must never stick high
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || force_shutdown_bit_r)
            force_shutdown_bit_r <= 1'b0; // [RULE6]
        else
            force_shutdown_bit_r <= sd_wr; // [RULE5]
    end
    assign shutdown_o = force_shutdown_bit_r;
    // no answer for the shutdown write: the device is already going down
    assign ack_o = wr_en_i && !sd_wr; // [RULE7]

    // read mux
    assign rdata_o = sel_d3 ? disch3_r :
                     sel_pg ? pgdly_r :
                     sel_sl ? slp_r :
                     8'h00; // shutdown reads zero [RULE6] [RULE12]

    // ========================================
    // discharge selects
    assign switch_two_discharge_sel_o = disch3_r[SW2_LSB +: 2]; // [RULE1]
    assign switch_one_discharge_sel_o = disch3_r[SW1_LSB +: 2]; // [RULE1]
    assign linreg_three_discharge_sel_o = disch3_r[LR3_LSB +: 2]; // [RULE1]

    // ========================================
    // buck one voltage selection
    wire sleep_pin = sleep_pin_sel_i ? control_input_six_sleep_i
                                     : control_input_three_sleep_i; // [RULE10]
    wire use_sleep = slp_r[SLP_EN_BIT] && !sleep_pin; // [RULE9]
    assign buck_one_vid_o = use_sleep ? slp_r[7:SLP_VID_LSB]
                                      : buck_one_normal_voltage_code_i;

    // ========================================
    // power-good delay
    logic [CNT_W-1:0] dly_cyc;
    always_comb
    begin
        unique case (pgdly_r[2:0]) // [RULE3]
            3'h0: dly_cyc = CNT_W'(DLY_X10_0 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h1: dly_cyc = CNT_W'(DLY_X10_1 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h2: dly_cyc = CNT_W'(DLY_X10_2 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h3: dly_cyc = CNT_W'(DLY_X10_3 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h4: dly_cyc = CNT_W'(DLY_X10_4 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h5: dly_cyc = CNT_W'(DLY_X10_5 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h6: dly_cyc = CNT_W'(DLY_X10_6 * CYC_PER_MS_X10 / DLY_SCALE);
            3'h7: dly_cyc = CNT_W'(DLY_X10_7 * CYC_PER_MS_X10 / DLY_SCALE);
        endcase
    end

    // count from rails good; pg after full delay
    // any dip of the rails restarts the whole delay from zero
    always_comb
    begin
        cnt_nxt = cnt_r;
        pg_nxt = pg_r;
        if (!rails_good_i)
        begin
            cnt_nxt = '0;
            pg_nxt = 1'b0;
        end
        else if (!pg_r)
        begin
            if (cnt_r + CNT_W'(1) >= dly_cyc)
                pg_nxt = 1'b1; // [RULE2]
            else
                cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (dev_rst)
        begin
            cnt_r <= '0;
            pg_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            pg_r <= pg_nxt;
        end
    end

    // output three: register level ignores delay
    assign general_output_three_o = (general_output_three_i2c_mode_i && !general_output_three_vtt_use_i)
                                    ? general_output_three_i2c_level_i : pg_r; // [RULE4]

    // ========================================
    // checks
    pg_waits_a: assert property (@(posedge ref_clk_i) disable iff (dev_rst)
        $rose(pg_r) |-> $past(rails_good_i)) // [RULE2]
        else $error("power good rose without rails good");
    sd_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        force_shutdown_bit_r |=> !force_shutdown_bit_r) // [RULE6]
        else $error("shutdown bit did not clear");
    sd_noack_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sd_wr |-> !ack_o) // [RULE7]
        else $error("shutdown write acknowledged");
    sd_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sd_wr |=> ##1 (slp_r == RST_BUCK_REGULATOR_ONE_SLP && !pg_r)) // [RULE5]
        else $error("registers not reset by shutdown");
    resv_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pgdly_r[7:3] == 5'h00 && disch3_r[7:6] == 2'h0) // [RULE12]
        else $error("reserved bits nonzero");
    sleep_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !slp_r[SLP_EN_BIT] |-> buck_one_vid_o ==
        buck_one_normal_voltage_code_i) // [RULE9]
        else $error("sleep code used while disabled");
    gpo_reg_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (general_output_three_i2c_mode_i && !general_output_three_vtt_use_i) |->
        general_output_three_o == general_output_three_i2c_level_i) // [RULE4]
        else $error("output three not register driven");
    disch_map_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        {switch_two_discharge_sel_o, switch_one_discharge_sel_o,
         linreg_three_discharge_sel_o} == disch3_r[5:0]) // [RULE1]
        else $error("discharge select mismatch");

    // ========================================
    // tolerance window for the power-good delay checks
    localparam int RUN_W = CNT_W + 1; // room for ten percent overshoot
    localparam int TOL_LO_NUM = 9; // lower bound, nine tenths
    localparam int TOL_HI_NUM = 11; // upper bound, eleven tenths
    localparam int TOL_DEN = 10; // tenths

    // helper: cycles since rails good, kept apart from the delay counter
    // so a broken counter cannot hide behind its own arithmetic
    logic [RUN_W-1:0] good_run_r;
    logic [RUN_W-1:0] good_run_nxt;
    logic [RUN_W-1:0] dly_min;
    logic [RUN_W-1:0] dly_max;

    // saturating count so a long good stretch cannot wrap to zero
    assign good_run_nxt = !rails_good_i ? '0 :
                          (&good_run_r) ? good_run_r :
                          good_run_r + RUN_W'(1);
    // window around the nominal count; one bit wider so the longest fits
    assign dly_min = RUN_W'((32'(dly_cyc) * TOL_LO_NUM) / TOL_DEN);
    assign dly_max = RUN_W'((32'(dly_cyc) * TOL_HI_NUM) / TOL_DEN + 1);

    // helper restarts with the device so it tracks the delay counter
    always_ff @(posedge ref_clk_i)
    begin
        if (dev_rst)
            good_run_r <= '0;
        else
            good_run_r <= good_run_nxt;
    end

    // power good never early and never late against the window
    pg_early_a: assert property (@(posedge ref_clk_i) disable iff (dev_rst)
        $rose(pg_r) |-> good_run_r >= dly_min) // [RULE2] [RULE3]
        else $error("power good rose before the delay window");
    pg_late_a: assert property (@(posedge ref_clk_i) disable iff (dev_rst)
        (rails_good_i && good_run_r >= dly_max) |=> pg_r) // [RULE3]
        else $error("power good missed the delay window");
    // once up, power good follows the rails only
    pg_hold_a: assert property (@(posedge ref_clk_i) disable iff (dev_rst)
        (pg_r && rails_good_i) |=> pg_r) // [RULE2]
        else $error("power good dropped with rails good");
    pg_drop_a: assert property (@(posedge ref_clk_i) disable iff (dev_rst)
        !rails_good_i |=> !pg_r) // [RULE2]
        else $error("power good held without rails good");
    // pin three shows the delayed power good unless register driven
    gpo_pg_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(general_output_three_i2c_mode_i && !general_output_three_vtt_use_i) |->
        general_output_three_o == pg_r) // [RULE2] [RULE4]
        else $error("output three not showing power good");

    // ========================================
    // shutdown walk: refused write, one-cycle pulse, registers at reset
    sequence sd_request_s;
        wr_en_i && addr_i == ADDR_SHUTDN && wdata_i[FORCE_SHUTDOWN_BIT_BIT];
    endsequence
    sequence sd_done_s;
        !shutdown_o && disch3_r == RST_DISCH3 &&
        pgdly_r == RST_POWER_GOOD_DELAY_ONE && slp_r == RST_BUCK_REGULATOR_ONE_SLP && !pg_r;
    endsequence
    sd_walk_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sd_request_s |=> shutdown_o ##1 sd_done_s) // [RULE5] [RULE6]
        else $error("shutdown walk broken");
    // reset brings the discharge register back, shutdown idle, pg low
    reset_vals_a: assert property (@(posedge ref_clk_i)
        rst_i |=> (disch3_r == RST_DISCH3 && !force_shutdown_bit_r && !pg_r)) // [RULE5]
        else $error("registers not at reset after reset");

    // ========================================
    // bus answers, reads and writes landing
    ack_plain_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_en_i && !(sel_sd && wdata_i[FORCE_SHUTDOWN_BIT_BIT])) |-> ack_o) // [RULE7]
        else $error("ordinary write not acknowledged");
    ack_only_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ack_o |-> wr_en_i) // [RULE7]
        else $error("acknowledge without a write");
    read_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(sel_d3 || sel_pg || sel_sl) |-> rdata_o == 8'h00) // [RULE12]
        else $error("unmapped or shutdown read not zero");
    wr_lands_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_en_i && sel_sl && !force_shutdown_bit_r) |=> slp_r == $past(wdata_i)) // [RULE8]
        else $error("sleep register write lost");
    disch_lands_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_en_i && sel_d3 && !force_shutdown_bit_r) |=>
        disch3_r == ($past(wdata_i) & MASK_DISCH3)) // [RULE1] [RULE12]
        else $error("discharge register write lost");
    pgdly_lands_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_en_i && sel_pg && !force_shutdown_bit_r) |=>
        pgdly_r == ($past(wdata_i) & MASK_POWER_GOOD_DELAY_ONE)) // [RULE3] [RULE12]
        else $error("delay register write lost");
    // sleep code takes over only with enable set and pin low
    sleep_use_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (slp_r[SLP_EN_BIT] && !sleep_pin) |->
        buck_one_vid_o == slp_r[7:SLP_VID_LSB]) // [RULE9] [RULE10]
        else $error("sleep code not used with pin low");
endmodule : pcr_regs
`default_nettype wire

// file: verif/pcr_host.sv
// host model that writes and reads the register slice
`timescale 1ns/1ps
`default_nettype none
module pcr_host (
    input wire logic clk_i, // clock
    input wire logic ack_i, // write acknowledge
    input wire logic [7:0] rdata_i, // read data
    output logic wr_en_o, // write strobe
    output logic [7:0] addr_o, // offset
    output logic [7:0] wdata_o // write data
);
    // idle bus at time zero
    initial
    begin
        wr_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // one write, acknowledge taken at the closing edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic ak);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        ak = ack_i;
        wr_en_o <= 1'b0;
        wdata_o <= ~d; // released data shows no stale value
        // no acknowledge is normal here; wait out the restart
        if (a == pcr_pkg::ADDR_SHUTDN && d[pcr_pkg::FORCE_SHUTDOWN_BIT_BIT])
            repeat (2) @(posedge clk_i);
    endtask : wr
    // combinational read, sampled mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        @(negedge clk_i);
        d = rdata_i;
    endtask : rd
endmodule : pcr_host
`default_nettype wire

// file: verif/pcr_regs_tb.sv
// self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_tb;
    import pcr_pkg::*;
    logic clk, rst, ack, we, rails, im, vtt, lvl, sel, s3, s6, so, g, ak;
    logic [7:0] ad, wd, rdata, rv;
    logic [6:0] norm, vid;
    logic [1:0] d2, d1, d0;
    int n_mismatch = 0;
    int compares = 0;
    int n_sd = 0;
    int n, e;
    typedef struct {logic [7:0] a, d, r; logic k;} pcr_row_s;
    pcr_row_s rows [5] = '{'{ADDR_DISCH3, 8'hff, 8'h3f, 1'b1},
        '{ADDR_POWER_GOOD_DELAY_ONE, 8'hff, 8'h07, 1'b1},
        '{ADDR_BUCK_REGULATOR_ONE_SLP, 8'ha5, 8'ha5, 1'b1},
        '{ADDR_SHUTDN, 8'h00, 8'h00, 1'b1},
        '{8'h50, 8'hff, 8'h00, 1'b1}};
    int dly [8] = '{DLY_X10_0, DLY_X10_1, DLY_X10_2, DLY_X10_3,
        DLY_X10_4, DLY_X10_5, DLY_X10_6, DLY_X10_7};
    pcr_host u_host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata),
        .wr_en_o(we), .addr_o(ad), .wdata_o(wd));
    pcr_regs #(.DLY_SCALE(1000)) u_dut (.ref_clk_i(clk), .rst_i(rst),
        .wr_en_i(we), .addr_i(ad), .wdata_i(wd), .rdata_o(rdata),
        .ack_o(ack), .buck_one_normal_voltage_code_i(norm),
        .sleep_pin_sel_i(sel), .control_input_three_sleep_i(s3),
        .control_input_six_sleep_i(s6), .rails_good_i(rails),
        .general_output_three_i2c_mode_i(im), .general_output_three_vtt_use_i(vtt), .general_output_three_i2c_level_i(lvl),
        .general_output_three_o(g), .switch_two_discharge_sel_o(d2),
        .switch_one_discharge_sel_o(d1), .linreg_three_discharge_sel_o(d0),
        .buck_one_vid_o(vid), .shutdown_o(so));
    // ========================================
    // clock and shutdown pulse counter
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (so === 1'b1) n_sd++;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    // drive sleep pins and check the active code
    task automatic pin(input logic ps, p3, p6, input logic [6:0] x);
        @(posedge clk);
        sel <= ps;
        s3 <= p3;
        s6 <= p6;
        @(negedge clk);
        chk({1'b0, vid}, {1'b0, x});
    endtask : pin
    // ========================================
    // main sequence
    initial
    begin
        {rst, rails, im, vtt, lvl, sel, s3, s6} = 8'h83;
        norm = 7'h2a;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        u_host.rd(ADDR_DISCH3, rv);
        chk(rv, RST_DISCH3);
        chk({2'b00, d2, d1, d0}, RST_DISCH3);
        u_host.rd(ADDR_BUCK_REGULATOR_ONE_SLP, rv);
        chk(rv, RST_BUCK_REGULATOR_ONE_SLP);
        $display("done: reset");
        foreach (rows[i])
        begin
            u_host.wr(rows[i].a, rows[i].d, ak);
            chk({7'h00, ak}, {7'h00, rows[i].k});
            u_host.rd(rows[i].a, rv);
            chk(rv, rows[i].r);
        end
        u_host.wr(ADDR_DISCH3, 8'h1b, ak);
        @(negedge clk);
        chk({2'b00, d2, d1, d0}, 8'h1b);
        $display("done: table");
        u_host.wr(ADDR_BUCK_REGULATOR_ONE_SLP, 8'h81, ak);
        pin(1'b0, 1'b0, 1'b1, 7'h40);
        pin(1'b0, 1'b1, 1'b0, 7'h2a);
        pin(1'b1, 1'b0, 1'b0, 7'h40);
        pin(1'b1, 1'b0, 1'b1, 7'h2a);
        u_host.wr(ADDR_BUCK_REGULATOR_ONE_SLP, 8'h80, ak);
        pin(1'b1, 1'b0, 1'b0, 7'h2a);
        $display("done: sleep");
        for (int c = 0; c < 8; c++)
        begin
            u_host.wr(ADDR_POWER_GOOD_DELAY_ONE, 8'(c), ak);
            e = dly[c] * CYC_PER_MS_X10 / 1000;
            @(posedge clk);
            rails <= 1'b1;
            n = 0;
            while (g !== 1'b1 && n < 1200)
            begin
                @(negedge clk);
                n++;
            end
            chk(8'(n >= e * 9 / 10 && n <= e * 11 / 10), 8'h01);
            if (n >= 1200) results();
            @(posedge clk);
            rails <= 1'b0;
            @(negedge clk);
            @(negedge clk);
            chk({7'h00, g}, 8'h00);
        end
        $display("done: power good");
        @(posedge clk);
        {im, lvl, rails} <= 3'h7;
        @(negedge clk);
        chk({7'h00, g}, 8'h01);
        @(posedge clk);
        lvl <= 1'b0;
        @(negedge clk);
        chk({7'h00, g}, 8'h00);
        @(posedge clk);
        {vtt, lvl} <= 2'h3;
        @(negedge clk);
        chk({7'h00, g}, 8'h00);
        @(posedge clk);
        {im, vtt, rails} <= 3'h0;
        $display("done: output three");
        u_host.wr(ADDR_SHUTDN, 8'h01, ak);
        chk({7'h00, ak}, 8'h00);
        chk(8'(n_sd), 8'h01);
        u_host.rd(ADDR_BUCK_REGULATOR_ONE_SLP, rv);
        chk(rv, RST_BUCK_REGULATOR_ONE_SLP);
        u_host.rd(ADDR_DISCH3, rv);
        chk(rv, RST_DISCH3);
        u_host.rd(ADDR_SHUTDN, rv);
        chk(rv, 8'h00);
        $display("done: shutdown");
        results();
    end
endmodule : pcr_regs_tb
`default_nettype wire
